// ==== pkg/incd_pkg.sv ====
// Shared constants, types and helpers for the interpolating NCO datapath
package incd_pkg;
  // Register offsets
  localparam logic [7:0] ADDR_FRAME_CFG = 8'h22;
  localparam logic [7:0] ADDR_MODE = 8'h28;
  localparam logic [7:0] ADDR_NCO_CTRL = 8'h30;
  localparam logic [7:0] ADDR_FTW_B3 = 8'h31;
  localparam logic [7:0] ADDR_FTW_B0 = 8'h34;
  // Field positions
  localparam int FRAME_TGT_LSB = 0;
  localparam int FRAME_REPEAT_BIT = 2;
  localparam int MODE_INTERP_LSB = 0;
  localparam int MODE_MOD_LSB = 2;
  localparam int CTRL_REQ_BIT = 0;
  localparam int CTRL_DONE_BIT = 1;
  localparam int CTRL_PULSE_DONE_BIT = 6;
  // Reset values
  localparam logic [2:0] FRAME_CFG_RST = 3'h0;
  localparam logic [3:0] MODE_RST = 4'h0;
  localparam logic [31:0] FTW_RST = 32'h0000_0000;
  // Frame target field codes
  localparam logic [1:0] TGT_FIFO = 2'h0;
  localparam logic [1:0] TGT_NCO = 2'h1;
  localparam logic [1:0] TGT_FIFO_NCO = 2'h2;
  // Interpolation codes: 2x, 4x, else 8x
  localparam logic [1:0] INTERP_2X = 2'h0;
  localparam logic [1:0] INTERP_4X = 2'h1;
  // Modulation codes
  localparam logic [1:0] MOD_OFF = 2'h0;
  localparam logic [1:0] MOD_FS4 = 2'h1;
  localparam logic [1:0] MOD_NCO = 2'h2;
  // Input buffer
  localparam int FIFO_DEPTH = 16;
  // Half-band side taps, outermost first, zero padded
  localparam int HB_NT [0:2] = '{14, 6, 3};
  localparam int HB_SH [0:2] = '{15, 12, 11};
  localparam int HB_C [0:2][0:13] = '{
    '{-4, 13, -32, 69, -134, 239, -401, 642, -994, 1512, -2307, 3665, -6638, 20754},
    '{-2, 17, -75, 238, -660, 2530, 0, 0, 0, 0, 0, 0, 0, 0},
    '{29, -214, 1209, 0, 0, 0, 0, 0, 0, 0, 0, 0, 0, 0}};
  // Quarter-wave sine table, 64 points per turn, half-step offset
  localparam logic signed [15:0] SIN_Q [0:15] = '{
    16'sh0648, 16'sh12C8, 16'sh1F1A, 16'sh2B1F, 16'sh36BA, 16'sh41CE, 16'sh4C3F, 16'sh55F5,
    16'sh5ED7, 16'sh66CF, 16'sh6DC9, 16'sh73B5, 16'sh7884, 16'sh7C29, 16'sh7E9C, 16'sh7FD8};
  localparam int MIX_SH = 15;

  typedef struct packed {
    logic signed [15:0] i;
    logic signed [15:0] q;
  } incd_iq_t;

  // Clamp a wide result to a 16-bit sample
  function automatic logic signed [15:0] sat16(input logic signed [39:0] v);
    if (v > 40'sh00_0000_7FFF) return 16'sh7FFF;
    if (v < -40'sh00_0000_8000) return -16'sh8000;
    return v[15:0];
  endfunction
endpackage

// ==== logic/incd_datapath.sv ====
// Interpolating half-band chain, fs/4 and NCO modulator, input FIFO
//
// Behaviour
// [RULE_01] Three half-band stages, each doubling rate, give 2x, 4x or 8x.
// [RULE_02] Filters treat I and Q separately; modulator treats them as one complex pair.
// [RULE_03] Host supplies true quadrature data when modulation is used.
// [RULE_04] In 8x mode host input rate stays at or below 200 MHz.
// [RULE_05] Stage one is the symmetric 55-tap half-band, centre 32768.
// [RULE_06] Stage two is the symmetric 23-tap half-band, centre 4096.
// [RULE_07] Stage three is the symmetric 11-tap half-band, centre 2048.
// [RULE_08] Coarse mode shifts the signal to a quarter of the DAC rate.
// [RULE_09] NCO mode mixes with a quadrature carrier and sums cross products.
// [RULE_10] Tuning word lives in four byte registers 0x31 to 0x34, MSB first.
// [RULE_11] NCO runs at the DAC clock, carrier up to half that rate.
// [RULE_12] Tuning word is twos complement; negative words give negative carriers.
// [RULE_13] Tuning word writes stay in shadow until an update event.
// [RULE_14] Request bit rising loads the tuning word, then sets the done bit.
// [RULE_15] Request bit falling clears the done bit and re-arms.
// [RULE_16] Register-request update is for cases without multi-device alignment.
// [RULE_17] Frame-triggered mode loads the tuning word on the frame rising edge.
// [RULE_18] Software sets frame target field to NCO-only or FIFO-and-NCO.
// [RULE_19] Software clears repeat-pulse bit for one-shot frame update.
// [RULE_20] After a frame-triggered load the pulse-done bit reads one.
// [RULE_21] Host holds a frame pulse at least one or two data periods.
// [RULE_22] One-shot acts on first pulse after target write; repeat acts always.
// [RULE_23] Software selects interpolation at 0x28 bits 1:0 before updates.
// [RULE_24] Longest filter first: 2x stage one, 4x one-two, 8x all three.
// [RULE_25] 32-bit phase accumulator adds active word each clock, drives sine/cosine.
`timescale 1ns/1ps

module incd_fifo #(
  parameter int W = 32,
  parameter int D = 16
) (
  input wire logic clk, // DAC clock
  input wire logic rst, // Sync reset, high
  input wire logic in_valid, // Write request
  output logic in_ready, // Space left
  input wire logic [W-1:0] in_data, // Write word
  output logic out_valid, // Word available
  input wire logic out_ready, // Read request
  output logic [W-1:0] out_data // Oldest word
);
  localparam int AW = $clog2(D);
  logic [W-1:0] mem [0:D-1];
  logic [AW:0] wp_r;
  logic [AW:0] rp_r;

  // Extra pointer bit tells full from empty
  assign in_ready = (wp_r ^ rp_r) != {1'b1, {AW{1'b0}}};
  assign out_valid = wp_r != rp_r;
  assign out_data = mem[rp_r[AW-1:0]];

  // Storage write
  always_ff @(posedge clk) begin
    if (in_valid && in_ready) begin
      mem[wp_r[AW-1:0]] <= in_data;
    end
  end

  // Pointers
  always_ff @(posedge clk) begin
    if (rst) begin
      wp_r <= '0;
      rp_r <= '0;
    end else begin
      if (in_valid && in_ready) begin
        wp_r <= wp_r + 1'b1;
      end
      if (out_valid && out_ready) begin
        rp_r <= rp_r + 1'b1;
      end
    end
  end
endmodule

module incd_hb #(
  parameter int STG = 0
) (
  input wire logic clk, // DAC clock
  input wire logic rst, // Sync reset, high
  input wire logic in_en, // Input-rate strobe
  input wire logic out_en, // Output-rate strobe
  input wire logic signed [15:0] x, // Input sample
  output logic signed [15:0] y // Output sample
);
  localparam int N = incd_pkg::HB_NT[STG];
  localparam int SH = incd_pkg::HB_SH[STG];
  logic signed [15:0] w_r [0:2*N-1];
  logic signed [39:0] acc;

  // Odd phase: only the nonzero symmetric taps, pre-added in pairs
  always_comb begin
    acc = '0;
    for (int j = 0; j < N; j++) begin
      acc = acc + 40'(incd_pkg::HB_C[STG][j]) * (40'(w_r[j]) + 40'(w_r[2*N-1-j])); // [RULE_05] [RULE_06] [RULE_07]
    end
  end

  // Delay line at input rate
  always_ff @(posedge clk) begin
    if (rst) begin
      for (int i = 0; i < 2*N; i++) begin
        w_r[i] <= '0;
      end
    end else if (in_en) begin
      w_r[0] <= x;
      for (int i = 1; i < 2*N; i++) begin
        w_r[i] <= w_r[i-1];
      end
    end
  end

  // Even phase is the centre tap, a pure power of two, so just the delayed sample
  always_ff @(posedge clk) begin
    if (rst) begin
      y <= '0;
    end else if (out_en) begin
      y <= in_en ? w_r[N] : incd_pkg::sat16(acc >>> SH); // [RULE_01]
    end
  end
endmodule

module incd_datapath (
  input wire logic clk, // DAC sample clock
  input wire logic rst, // Sync reset, high
  input wire logic host_valid, // Host sample pair valid
  output logic host_ready, // FIFO can take a pair
  input wire incd_pkg::incd_iq_t host_data, // Host I/Q pair
  input wire logic frame_in, // Frame pin, async
  input wire logic [7:0] reg_addr, // Register offset
  input wire logic [7:0] reg_wdata, // Write byte
  input wire logic reg_wr, // Write strobe
  input wire logic reg_rd, // Read strobe
  output logic [7:0] reg_rdata, // Read byte, one cycle later
  output incd_pkg::incd_iq_t dac_out // Sample to DAC cores
);
  logic [2:0] frame_cfg_r;
  logic [3:0] mode_r;
  logic req_r;
  logic done_r;
  logic pulse_done_r;
  logic armed_r;
  logic [31:0] ftw_sh_r;
  logic [31:0] ftw_r;
  logic [31:0] phase_r;
  logic [2:0] cnt_r;
  logic [1:0] q4_r;
  logic fr_s1_r;
  logic fr_s2_r;
  logic fr_s3_r;
  logic fr_rise;
  logic spi_load;
  logic frame_load;
  logic wr_frame;
  logic [1:0] used;
  incd_pkg::incd_iq_t fifo_q;
  logic fifo_v;
  logic [3:0] st_in;
  logic [3:0] st_out;
  logic signed [15:0] chain [0:1][0:3];
  logic signed [15:0] bb_i;
  logic signed [15:0] bb_q;
  logic signed [15:0] sn;
  logic signed [15:0] cs;

  // Input buffer; its ready is the host's back-pressure
  incd_fifo #(
    .W($bits(incd_pkg::incd_iq_t)),
    .D(incd_pkg::FIFO_DEPTH)
  ) u_fifo (
    .clk(clk),
    .rst(rst),
    .in_valid(host_valid),
    .in_ready(host_ready),
    .in_data(host_data),
    .out_valid(fifo_v),
    .out_ready(st_in[0]),
    .out_data(fifo_q)
  );

  // Stages in use; code 3 is treated as 8x
  always_comb begin
    if (mode_r[1:0] == incd_pkg::INTERP_2X) begin
      used = 2'h1;
    end else if (mode_r[1:0] == incd_pkg::INTERP_4X) begin
      used = 2'h2;
    end else begin
      used = 2'h3;
    end
  end

  // Rate divider: stage k in at fdac/2^(used-k), out at twice that
  always_ff @(posedge clk) begin
    if (rst) begin
      cnt_r <= '0;
    end else begin
      cnt_r <= cnt_r + 3'h1;
    end
  end

  // Underflow feeds zeros rather than stalling the DAC
  assign chain[0][0] = fifo_v ? fifo_q.i : '0;
  assign chain[1][0] = fifo_v ? fifo_q.q : '0;

  // Longest filter at the lowest rate, then the shorter ones
  for (genvar k = 0; k < 3; k++) begin : g_stage
    logic [2:0] in_m;
    logic [2:0] out_m;
    assign in_m = 3'((1 << (int'(used) - k)) - 1);
    assign out_m = 3'((1 << (int'(used) - k - 1)) - 1);
    assign st_in[k] = (k < int'(used)) && ((cnt_r & in_m) == 3'h0); // [RULE_24]
    assign st_out[k] = (k < int'(used)) && ((cnt_r & out_m) == 3'h0); // [RULE_24]
    for (genvar c = 0; c < 2; c++) begin : g_ch
      incd_hb #(
        .STG(k)
      ) u_hb (
        .clk(clk),
        .rst(rst),
        .in_en(st_in[k]),
        .out_en(st_out[k]),
        .x(chain[c][k]),
        .y(chain[c][k+1])
      ); // [RULE_02]
    end
  end
  assign st_in[3] = 1'b0;
  assign st_out[3] = 1'b0;

  // Chain tap that matches the chosen ratio
  assign bb_i = chain[0][used];
  assign bb_q = chain[1][used];

  // Frame pin synchroniser; edge found on the second and third flops
  always_ff @(posedge clk) begin
    if (rst) begin
      fr_s1_r <= 1'b0;
      fr_s2_r <= 1'b0;
      fr_s3_r <= 1'b0;
    end else begin
      fr_s1_r <= frame_in;
      fr_s2_r <= fr_s1_r;
      fr_s3_r <= fr_s2_r;
    end
  end
  assign fr_rise = fr_s2_r && !fr_s3_r;

  // Update events
  assign wr_frame = reg_wr && (reg_addr == incd_pkg::ADDR_FRAME_CFG);
  assign spi_load = reg_wr && (reg_addr == incd_pkg::ADDR_NCO_CTRL)
    && reg_wdata[incd_pkg::CTRL_REQ_BIT] && !req_r; // [RULE_14]
  assign frame_load = fr_rise
    && ((frame_cfg_r[1:0] == incd_pkg::TGT_NCO) || (frame_cfg_r[1:0] == incd_pkg::TGT_FIFO_NCO))
    && (frame_cfg_r[incd_pkg::FRAME_REPEAT_BIT] || armed_r); // [RULE_17] [RULE_22]

  // Configuration and shadow tuning word
  always_ff @(posedge clk) begin
    if (rst) begin
      frame_cfg_r <= incd_pkg::FRAME_CFG_RST;
      mode_r <= incd_pkg::MODE_RST;
      req_r <= 1'b0;
      ftw_sh_r <= incd_pkg::FTW_RST;
    end else if (reg_wr) begin
      if (reg_addr == incd_pkg::ADDR_FRAME_CFG) begin
        frame_cfg_r <= reg_wdata[2:0];
      end else if (reg_addr == incd_pkg::ADDR_MODE) begin
        mode_r <= reg_wdata[3:0];
      end else if (reg_addr == incd_pkg::ADDR_NCO_CTRL) begin
        req_r <= reg_wdata[incd_pkg::CTRL_REQ_BIT];
      end else if (reg_addr >= incd_pkg::ADDR_FTW_B3 && reg_addr <= incd_pkg::ADDR_FTW_B0) begin
        // Lowest offset holds the top byte
        ftw_sh_r[8*(3-(reg_addr-incd_pkg::ADDR_FTW_B3)) +: 8] <= reg_wdata; // [RULE_10] [RULE_13]
      end
    end
  end

  // Active tuning word changes only on an update event
  always_ff @(posedge clk) begin
    if (rst) begin
      ftw_r <= incd_pkg::FTW_RST;
    end else if (spi_load || frame_load) begin
      ftw_r <= ftw_sh_r; // [RULE_13] [RULE_14] [RULE_17]
    end
  end

  // Register-request handshake: done follows the load, drops with the request
  always_ff @(posedge clk) begin
    if (rst) begin
      done_r <= 1'b0;
    end else if (spi_load) begin
      done_r <= 1'b1; // [RULE_14]
    end else if (reg_wr && reg_addr == incd_pkg::ADDR_NCO_CTRL && !reg_wdata[incd_pkg::CTRL_REQ_BIT]) begin
      done_r <= 1'b0; // [RULE_15]
    end
  end

  // One-shot arming and frame done flag; a load beats a same-cycle clear
  always_ff @(posedge clk) begin
    if (rst) begin
      armed_r <= 1'b0;
      pulse_done_r <= 1'b0;
    end else begin
      if (frame_load) begin
        armed_r <= 1'b0; // [RULE_22]
        pulse_done_r <= 1'b1; // [RULE_20]
      end else if (wr_frame) begin
        armed_r <= 1'b1; // [RULE_22]
        pulse_done_r <= 1'b0;
      end
    end
  end

  // Read port
  always_ff @(posedge clk) begin
    if (rst) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      if (reg_addr == incd_pkg::ADDR_FRAME_CFG) begin
        reg_rdata <= {5'h00, frame_cfg_r};
      end else if (reg_addr == incd_pkg::ADDR_MODE) begin
        reg_rdata <= {4'h0, mode_r};
      end else if (reg_addr == incd_pkg::ADDR_NCO_CTRL) begin
        reg_rdata <= {1'b0, pulse_done_r, 4'h0, done_r, req_r};
      end else if (reg_addr >= incd_pkg::ADDR_FTW_B3 && reg_addr <= incd_pkg::ADDR_FTW_B0) begin
        reg_rdata <= ftw_sh_r[8*(3-(reg_addr-incd_pkg::ADDR_FTW_B3)) +: 8];
      end else begin
        reg_rdata <= 8'h00;
      end
    end
  end

  // Phase accumulator at the DAC rate; wraps, so signed words tune negative
  always_ff @(posedge clk) begin
    if (rst) begin
      phase_r <= '0;
      q4_r <= '0;
    end else begin
      phase_r <= phase_r + ftw_r; // [RULE_11] [RULE_12] [RULE_25]
      q4_r <= q4_r + 2'h1;
    end
  end

  // Sine and cosine from the top six phase bits, quarter table mirrored
  function automatic logic signed [15:0] sine(input logic [5:0] p);
    logic [3:0] ix;
    ix = p[4] ? ~p[3:0] : p[3:0];
    return p[5] ? -incd_pkg::SIN_Q[ix] : incd_pkg::SIN_Q[ix];
  endfunction
  assign sn = sine(phase_r[31:26]); // [RULE_25]
  assign cs = sine(phase_r[31:26] + 6'h10);

  // Modulator and output register
  always_ff @(posedge clk) begin
    if (rst) begin
      dac_out <= '0;
    end else if (mode_r[3:2] == incd_pkg::MOD_NCO) begin
      // Complex multiply: cross products summed back into I and Q
      dac_out.i <= incd_pkg::sat16((40'(bb_i) * 40'(cs) - 40'(bb_q) * 40'(sn)) >>> incd_pkg::MIX_SH); // [RULE_09]
      dac_out.q <= incd_pkg::sat16((40'(bb_i) * 40'(sn) + 40'(bb_q) * 40'(cs)) >>> incd_pkg::MIX_SH); // [RULE_09]
    end else if (mode_r[3:2] == incd_pkg::MOD_FS4) begin
      // Quarter-rate rotation needs no multiplier
      case (q4_r)
        2'h0: dac_out <= '{i: bb_i, q: bb_q}; // [RULE_08]
        2'h1: dac_out <= '{i: incd_pkg::sat16(-40'(bb_q)), q: bb_i};
        2'h2: dac_out <= '{i: incd_pkg::sat16(-40'(bb_i)), q: incd_pkg::sat16(-40'(bb_q))};
        default: dac_out <= '{i: bb_q, q: incd_pkg::sat16(-40'(bb_i))};
      endcase
    end else begin
      dac_out <= '{i: bb_i, q: bb_q};
    end
  end
endmodule

// ==== dv/incd_datapath_sva.sv ====
// Port-level checks of the interpolating NCO datapath
`timescale 1ns/1ps
module incd_datapath_sva (
  input wire logic clk, // DAC clock
  input wire logic rst, // Sync reset
  input wire logic host_valid, // Pair offered
  input wire logic host_ready, // FIFO space
  input wire incd_pkg::incd_iq_t host_data, // Offered pair
  input wire logic frame_in, // Frame pin
  input wire logic [7:0] reg_addr, // Offset
  input wire logic [7:0] reg_wdata, // Write byte
  input wire logic reg_wr, // Write strobe
  input wire logic reg_rd, // Read strobe
  input wire logic [7:0] reg_rdata, // Read byte
  input wire incd_pkg::incd_iq_t dac_out // Output pair
);
  logic req_r;
  logic seen_r;
  logic wr30;
  logic rd30;
  // Decoded accesses to the update control byte
  assign wr30 = reg_wr && reg_addr == 8'h30;
  assign rd30 = reg_rd && reg_addr == 8'h30 && !reg_wr;
  // Copy of the request bit, so edges can be told from repeats
  always_ff @(posedge clk) begin
    if (rst) req_r <= 1'b0;
    else if (wr30) req_r <= reg_wdata[0];
  end
  // Set once any pair has entered the FIFO
  always_ff @(posedge clk) begin
    if (rst) seen_r <= 1'b0;
    else if (host_valid && host_ready) seen_r <= 1'b1;
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  property p_ftw_back;
    reg_wr && reg_addr == 8'h31 ##1 reg_rd && reg_addr == 8'h31 && !reg_wr |=> reg_rdata == $past(reg_wdata, 2);
  endproperty
  a_ftw_back: assert property (p_ftw_back) else $error("tuning byte readback wrong");
  property p_unmapped;
    reg_rd && !(reg_addr inside {8'h22, 8'h28, [8'h30:8'h34]}) |=> reg_rdata == 8'h00;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  property p_req_done;
    wr30 && reg_wdata[0] && !req_r ##1 rd30 |=> reg_rdata[1:0] == 2'h3;
  endproperty
  a_req_done: assert property (p_req_done) else $error("load done not set");
  property p_req_clear;
    wr30 && !reg_wdata[0] ##1 rd30 |=> reg_rdata[1:0] == 2'h0;
  endproperty
  a_req_clear: assert property (p_req_clear) else $error("load done not cleared");
  property p_pulse_clear;
    !frame_in [*4] ##0 reg_wr && reg_addr == 8'h22 ##2 rd30 |=> !reg_rdata[6];
  endproperty
  a_pulse_clear: assert property (p_pulse_clear) else $error("pulse done not cleared");
  property p_rd_hold;
    !reg_rd |=> $stable(reg_rdata);
  endproperty
  a_rd_hold: assert property (p_rd_hold) else $error("read byte moved");
  property p_mode_back;
    reg_wr && reg_addr == 8'h28 ##1 reg_rd && reg_addr == 8'h28 && !reg_wr
      |=> ((reg_rdata ^ $past(reg_wdata, 2)) & 8'h0F) == 8'h00;
  endproperty
  a_mode_back: assert property (p_mode_back) else $error("mode readback wrong");
  property p_cfg_back;
    reg_wr && reg_addr == 8'h22 ##1 reg_rd && reg_addr == 8'h22 && !reg_wr
      |=> ((reg_rdata ^ $past(reg_wdata, 2)) & 8'h07) == 8'h00;
  endproperty
  a_cfg_back: assert property (p_cfg_back) else $error("frame config readback wrong");
  property p_quiet;
    !seen_r |-> dac_out == 32'h00000000;
  endproperty
  a_quiet: assert property (p_quiet) else $error("output moved without input");
endmodule
bind incd_datapath incd_datapath_sva chk_u (.clk(clk), .rst(rst), .host_valid(host_valid),
  .host_ready(host_ready), .host_data(host_data), .frame_in(frame_in), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .dac_out(dac_out));

// ==== dv/incd_host_model.sv ====
// Host side: streams a held I/Q pair and makes frame pulses
`timescale 1ns/1ps
module incd_host_model (
  input wire logic clk, // DAC clock
  input wire logic rst, // Sync reset
  input wire logic go, // Offer pairs
  input wire incd_pkg::incd_iq_t level, // Pair to send
  input wire logic frame_req, // Start a frame pulse
  input wire logic host_ready, // FIFO space
  output logic host_valid = 1'b0, // Pair offered
  output incd_pkg::incd_iq_t host_data = 32'h00000000, // Offered pair
  output logic frame_in, // Frame pin
  output int taken // Pairs accepted
);
  logic [1:0] fcnt_r;
  // Offer held while refused; idle data is inverted, never stale
  always_ff @(posedge clk) begin
    if (rst) begin
      host_valid <= 1'b0;
      taken <= 0;
    end else begin
      if (host_valid && host_ready) taken <= taken + 1;
      if (!host_valid || host_ready) begin
        host_valid <= go;
        host_data <= go ? level : ~host_data;
      end
    end
  end
  // Frame pulse three clocks wide, longer than the minimum
  always_ff @(posedge clk) begin
    if (rst) fcnt_r <= 2'h0;
    else if (frame_req) fcnt_r <= 2'h3;
    else if (fcnt_r != 2'h0) fcnt_r <= fcnt_r - 2'h1;
  end
  assign frame_in = fcnt_r != 2'h0;
endmodule

// ==== dv/incd_datapath_tb.sv ====
// Self-checking bench for the interpolating NCO datapath
`timescale 1ns/1ps
module incd_datapath_tb;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic go = 1'b0;
  logic frame_req = 1'b0;
  incd_pkg::incd_iq_t level = 32'h03E80000;
  logic host_valid;
  logic host_ready;
  incd_pkg::incd_iq_t host_data;
  logic frame_in;
  int taken;
  logic [7:0] reg_addr = 8'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [7:0] reg_rdata;
  incd_pkg::incd_iq_t dac_out;
  int n_mismatch = 0;
  int check_count = 0;
  int cyc = 0;
  logic [7:0] map [7] = '{8'h22, 8'h28, 8'h30, 8'h31, 8'h32, 8'h33, 8'h34};
  // 40 MHz clock
  always #12.5 clk = ~clk;
  incd_datapath dut_u (.clk(clk), .rst(rst), .host_valid(host_valid), .host_ready(host_ready),
    .host_data(host_data), .frame_in(frame_in), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .dac_out(dac_out));
  incd_host_model host_u (.clk(clk), .rst(rst), .go(go), .level(level), .frame_req(frame_req),
    .host_ready(host_ready), .host_valid(host_valid), .host_data(host_data), .frame_in(frame_in),
    .taken(taken));
  task automatic test_done();
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  // Hang guard, well above the expected run
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      n_mismatch++;
      test_done();
    end
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // Register tasks start at a falling edge and end at one; a strobe stays up
  // until the next access or idle, so back-to-back calls never glitch it
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    reg_addr = a;
    reg_wdata = d;
    reg_rd = 1'b0;
    reg_wr = 1'b1;
    @(negedge clk);
  endtask
  task automatic rc(input logic [7:0] a, input logic [7:0] exp);
    reg_addr = a;
    reg_wr = 1'b0;
    reg_rd = 1'b1;
    @(negedge clk);
    chk({24'h000000, reg_rdata}, {24'h000000, exp});
  endtask
  task automatic idle(input int n);
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    repeat (n) @(negedge clk);
  endtask
  task automatic pulse();
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    frame_req = 1'b1;
    @(negedge clk);
    frame_req = 1'b0;
    idle(8);
  endtask
  // Write a tuning word, optionally through the request handshake
  task automatic ftw(input logic [31:0] w, input logic upd);
    for (int k = 0; k < 4; k++) wr(8'(8'h31 + k), w[31 - 8 * k -: 8]);
    if (upd) begin
      wr(8'h30, 8'h01);
      wr(8'h30, 8'h00);
    end
    idle(40);
  endtask
  // Rotation sense of consecutive outputs: 1 up, -1 down, 0 still
  task automatic rot(input int dir);
    incd_pkg::incd_iq_t p;
    int z;
    int m;
    for (int k = 0; k < 8; k++) begin
      p = dac_out;
      @(negedge clk);
      z = p.i * dac_out.q - p.q * dac_out.i;
      m = dac_out.i * dac_out.i + dac_out.q * dac_out.q;
      chk(32'((z > 0) - (z < 0)), 32'(dir));
      chk(32'(m > 810000 && m < 1002002), 32'h00000001);
    end
  endtask
  initial begin
    int t0;
    int m;
    logic neg;
    repeat (12) @(negedge clk);
    rst = 1'b0;
    foreach (map[j]) rc(map[j], 8'h00);
    rc(8'h35, 8'h00);
    for (int k = 0; k < 4; k++) begin
      wr(8'(8'h31 + k), 8'(8'hA0 + k));
      rc(8'(8'h31 + k), 8'(8'hA0 + k));
    end
    $display("test registers done");
    wr(8'h30, 8'h01);
    rc(8'h30, 8'h03);
    wr(8'h30, 8'h00);
    rc(8'h30, 8'h00);
    wr(8'h30, 8'h01);
    rc(8'h30, 8'h03);
    wr(8'h30, 8'h00);
    $display("test request done");
    for (int t = 0; t < 3; t++) begin
      wr(8'h22, 8'(t));
      rc(8'h22, 8'(t));
      rc(8'h30, 8'h00);
      pulse();
      rc(8'h30, t == 0 ? 8'h00 : 8'h40);
    end
    $display("test frame flag done");
    for (int r = 0; r < 4; r++) begin
      wr(8'h28, 8'(r));
      rc(8'h28, 8'(r));
      go = 1'b1;
      idle(400);
      chk(dac_out, 32'h03E80000);
      t0 = taken;
      idle(64);
      m = taken - t0 - (64 >> (r > 1 ? 3 : r + 1));
      chk(32'(m >= -1 && m <= 1), 32'h00000001);
      go = 1'b0;
      idle(600);
      chk(dac_out, 32'h00000000);
    end
    $display("test interpolation done");
    wr(8'h28, 8'h04);
    go = 1'b1;
    idle(400);
    neg = 1'b0;
    for (int k = 0; k < 8; k++) begin
      @(negedge clk);
      chk(32'(dac_out.i * dac_out.i + dac_out.q * dac_out.q), 32'd1000000);
      neg = neg | (dac_out.i == -16'sd1000);
    end
    chk(32'(neg), 32'h00000001);
    $display("test coarse shift done");
    wr(8'h28, 8'h08);
    ftw(32'h00000000, 1'b1);
    rot(0);
    ftw(32'h40000000, 1'b0);
    rot(0);
    ftw(32'h40000000, 1'b1);
    rot(1);
    ftw(32'hC0000000, 1'b1);
    rot(-1);
    ftw(32'h40000000, 1'b0);
    wr(8'h22, 8'h01);
    pulse();
    rot(1);
    // One-shot: a second pulse without a new target write must not load
    ftw(32'hC0000000, 1'b0);
    pulse();
    rot(1);
    // Repeat mode: every pulse loads the pending word
    wr(8'h22, 8'h05);
    pulse();
    rot(-1);
    ftw(32'h40000000, 1'b0);
    pulse();
    rot(1);
    $display("test carrier done");
    test_done();
  end
endmodule
